/* File: logic/scgate_map.vh */
// Purpose: Register map and field constants of the sleep clock gate block
// Assumes: Byte addresses on a 32-bit Wishbone bus, word aligned
// Notes: Shared by the gate controller, its checker and its bench
`ifndef SCGATE_MAP_VH
`define SCGATE_MAP_VH

// Register byte offsets
`define SCG_OFF_RUN 12'h104
`define SCG_OFF_SLEEP 12'h114
`define SCG_OFF_DEEP 12'h124
`define SCG_OFF_CFG 12'h130
`define SCG_OFF_STAT 12'h140
`define SCG_OFF_MASK 12'h144
`define SCG_ADR_W 12

// Implemented enable bits, reserved bits read zero
`define SCG_IMPL_MASK 32'h0707_1013
`define SCG_GATE_RST 32'h0000_0000
`define SCG_ZERO 32'h0000_0000

// Unit enable bit positions
`define SCG_POS_ASER0 5'h00
`define SCG_POS_ASER1 5'h01
`define SCG_POS_SSER 5'h04
`define SCG_POS_TWIRE 5'h0c
`define SCG_POS_TMR0 5'h10
`define SCG_POS_TMR1 5'h11
`define SCG_POS_TMR2 5'h12
`define SCG_POS_CMP0 5'h18
`define SCG_POS_CMP1 5'h19
`define SCG_POS_CMP2 5'h1a
`define SCG_UNITS 10

// Run clock config: auto clock gating select
`define SCG_CFG_AUTO_BIT 0
`define SCG_CFG_MASK 32'h0000_0001
`define SCG_CFG_RST 32'h0000_0000

// Operating modes
`define SCG_MODE_RUN 2'h0
`define SCG_MODE_SLEEP 2'h1
`define SCG_MODE_DEEP 2'h2

`endif

/* File: logic/scg_sleep_gate.v */
// Purpose: Run, sleep and deep-sleep clock gate enables for ten peripheral units
// Assumes: Single clock, classic Wishbone slave, peripheral strobes synchronous
// Notes: Unit enables are registered so they change one cycle after the cause
//
// Contract
// - Each implemented bit of the sleep gate register enables the clock of one unit.
// - A one in the applied enable clocks its unit, a zero leaves it unclocked.
// - An access to a unit whose clock is gated off raises a bus fault.
// - After reset every enable bit of the sleep gate register is zero.
// - The run register applies while running, sleep in Sleep and deep-sleep in Deep-Sleep.
// - The sleep and deep-sleep settings apply only while auto clock gating is selected.
// - The sleep gate register is a 32-bit word at offset 0x114.
// - Bits 18, 17 and 16 enable timers two, one and zero and are read-write.
// - Bit 12 enables the two-wire serial unit and is read-write.
// - Bit 4 enables the synchronous serial unit and is read-write.
// - Bits 1 and 0 enable asynchronous serial units one and zero and are read-write.
// - Reserved bits are read-only and read as zero.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
`include "scgate_map.vh"

module scg_sleep_gate (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`SCG_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Power mode requests from the system
  input wire sleepMode,
  input wire deepSleepMode,
  // Peripheral access strobes, one per unit
  input wire [`SCG_UNITS-1:0] periphAccess,
  // Gate outputs
  output reg [`SCG_UNITS-1:0] unitClkEn,
  output reg [1:0] activeMode,
  output reg busFault,
  output reg [`SCG_UNITS-1:0] faultUnit,
  // Interrupt
  output reg irq
);

  // Unit index to register bit position
  function [4:0] unitPos;
    input integer idx;
    begin
      case (idx)
        0: unitPos = `SCG_POS_ASER0;
        1: unitPos = `SCG_POS_ASER1;
        2: unitPos = `SCG_POS_SSER;
        3: unitPos = `SCG_POS_TWIRE;
        4: unitPos = `SCG_POS_TMR0;
        5: unitPos = `SCG_POS_TMR1;
        6: unitPos = `SCG_POS_TMR2;
        7: unitPos = `SCG_POS_CMP0;
        8: unitPos = `SCG_POS_CMP1;
        default: unitPos = `SCG_POS_CMP2;
      endcase
    end
  endfunction

  // Byte lane mask from Wishbone select
  function [31:0] laneMask;
    input [3:0] sel;
    begin
      laneMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // Masked write merge, reserved bits forced to zero
  function [31:0] mergeWrite;
    input [31:0] old;
    input [31:0] data;
    input [3:0] sel;
    input [31:0] impl;
    begin
      mergeWrite = ((old & ~laneMask(sel)) | (data & laneMask(sel))) & impl;
    end
  endfunction

  // Register state
  reg [31:0] runGate;
  reg [31:0] sleepGate;
  reg [31:0] deepGate;
  reg [31:0] runCfg;
  reg [31:0] faultStat;
  reg [31:0] faultMask;

  // Bus decode
  wire busReq = wb_cyc_i & wb_stb_i;
  // Write lands on the edge that samples ack, as the master expects
  wire wrDone = busReq & wb_we_i & wb_ack_o;
  wire hitRun = (wb_adr_i == `SCG_OFF_RUN);
  wire hitSleep = (wb_adr_i == `SCG_OFF_SLEEP);
  wire hitDeep = (wb_adr_i == `SCG_OFF_DEEP);
  wire hitCfg = (wb_adr_i == `SCG_OFF_CFG);
  wire hitStat = (wb_adr_i == `SCG_OFF_STAT);
  wire hitMask = (wb_adr_i == `SCG_OFF_MASK);

  // Mode and applied gate selection
  wire autoGate = runCfg[`SCG_CFG_AUTO_BIT];
  reg [1:0] next_activeMode;
  reg [31:0] appliedGate;

  always @* begin
    next_activeMode = `SCG_MODE_RUN;
    appliedGate = runGate;
    // Without auto gating the run settings hold in every mode
    if (autoGate && deepSleepMode) begin
      next_activeMode = `SCG_MODE_DEEP;
    end else if (autoGate && sleepMode) begin
      next_activeMode = `SCG_MODE_SLEEP;
    end
    case (next_activeMode)
      `SCG_MODE_RUN: appliedGate = runGate;
      `SCG_MODE_SLEEP: appliedGate = sleepGate;
      `SCG_MODE_DEEP: appliedGate = deepGate;
      default: appliedGate = runGate;
    endcase
  end

  // Per-unit enable and fault detection
  wire [`SCG_UNITS-1:0] next_unitClkEn;
  wire [`SCG_UNITS-1:0] gatedHit;
  wire [31:0] faultSet;

  genvar gi;
  generate
    for (gi = 0; gi < `SCG_UNITS; gi = gi + 1) begin : gUnit
      assign next_unitClkEn[gi] = appliedGate[unitPos(gi)];
      // Compare against the enable the unit really sees this cycle
      assign gatedHit[gi] = periphAccess[gi] & ~unitClkEn[gi];
    end
  endgenerate

  // Fault flags share the gate register layout
  reg [31:0] faultSetVec;
  integer fi;
  always @* begin
    faultSetVec = `SCG_ZERO;
    for (fi = 0; fi < `SCG_UNITS; fi = fi + 1) begin
      faultSetVec[unitPos(fi)] = gatedHit[fi];
    end
  end
  assign faultSet = faultSetVec;

  // Gate registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      runGate <= `SCG_GATE_RST;
      sleepGate <= `SCG_GATE_RST;
      deepGate <= `SCG_GATE_RST;
      runCfg <= `SCG_CFG_RST;
    end else if (wrDone) begin
      if (hitRun) begin
        runGate <= mergeWrite(runGate, wb_dat_i, wb_sel_i, `SCG_IMPL_MASK);
      end
      // Only implemented bits store; reserved bits stay zero
      if (hitSleep) begin
        sleepGate <= mergeWrite(sleepGate, wb_dat_i, wb_sel_i, `SCG_IMPL_MASK);
      end
      if (hitDeep) begin
        deepGate <= mergeWrite(deepGate, wb_dat_i, wb_sel_i, `SCG_IMPL_MASK);
      end
      if (hitCfg) begin
        runCfg <= mergeWrite(runCfg, wb_dat_i, wb_sel_i, `SCG_CFG_MASK);
      end
    end
  end

  // Sticky fault status, write one to clear, a new fault beats the clear
  wire [31:0] statClr = (wrDone && hitStat) ? (wb_dat_i & laneMask(wb_sel_i)) : `SCG_ZERO;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      faultStat <= `SCG_ZERO;
      faultMask <= `SCG_ZERO;
    end else begin
      faultStat <= ((faultStat & ~statClr) | faultSet) & `SCG_IMPL_MASK;
      if (wrDone && hitMask) begin
        faultMask <= mergeWrite(faultMask, wb_dat_i, wb_sel_i, `SCG_IMPL_MASK);
      end
    end
  end

  // Read mux
  reg [31:0] rdData;
  always @* begin
    rdData = `SCG_ZERO;
    case (wb_adr_i)
      `SCG_OFF_RUN: rdData = runGate;
      `SCG_OFF_SLEEP: rdData = sleepGate & `SCG_IMPL_MASK;
      `SCG_OFF_DEEP: rdData = deepGate;
      `SCG_OFF_CFG: rdData = runCfg;
      `SCG_OFF_STAT: rdData = faultStat;
      `SCG_OFF_MASK: rdData = faultMask;
      default: rdData = `SCG_ZERO;
    endcase
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `SCG_ZERO;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
      if (busReq && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= rdData;
      end else begin
        wb_dat_o <= `SCG_ZERO;
      end
    end
  end

  // Registered outputs
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unitClkEn <= {`SCG_UNITS{1'b0}};
      activeMode <= `SCG_MODE_RUN;
      busFault <= 1'b0;
      faultUnit <= {`SCG_UNITS{1'b0}};
      irq <= 1'b0;
    end else begin
      unitClkEn <= next_unitClkEn;
      activeMode <= next_activeMode;
      busFault <= |gatedHit;
      faultUnit <= gatedHit;
      // Level interrupt tracks the next status, so it rises with the status bit
      irq <= |(((faultStat & ~statClr) | faultSet) & faultMask);
    end
  end

endmodule

/* File: dv/scg_sleep_gate_checker.sv */
// Purpose: Bus, gating and fault checks on the sleep clock gate block
// Assumes: Sees only the ports of the block
// Notes: Bound from the bench top file
`timescale 1ns/1ns
`include "scgate_map.vh"
module scg_sleep_gate_checker (
  // Clock and reset
  input logic sys_clk,
  input logic rst_n,
  // Bus
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  // Modes and strobes
  input logic sleepMode,
  input logic deepSleepMode,
  input logic [`SCG_UNITS-1:0] periphAccess,
  // Gate outputs
  input logic [`SCG_UNITS-1:0] unitClkEn,
  input logic [1:0] activeMode,
  input logic busFault,
  input logic [`SCG_UNITS-1:0] faultUnit,
  input logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over two cycles");
  AST_IDLE_DATA: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_RSVD: assert property (wb_ack_o |-> (wb_dat_o & ~`SCG_IMPL_MASK) == 32'h0)
    else $error("reserved bit reads one");
  AST_FAULT: assert property (|(periphAccess & ~unitClkEn) |=> busFault)
    else $error("gated access without fault");
  AST_FAULT_UNIT: assert property (busFault |-> faultUnit == $past(periphAccess & ~unitClkEn))
    else $error("wrong faulting units");
  AST_RUN: assert property (!sleepMode && !deepSleepMode |=> activeMode == `SCG_MODE_RUN)
    else $error("run mode not applied");
  AST_DEEP: assert property (deepSleepMode |=> activeMode != `SCG_MODE_SLEEP)
    else $error("sleep applied in deep sleep");
  AST_RST: assert property ($rose(rst_n) |-> unitClkEn == '0 && !busFault)
    else $error("enables set after reset");
  AST_IRQ: assert property ($rose(irq) |-> busFault || $past(wb_ack_o, 2))
    else $error("interrupt without cause");
  cover property (busFault);
  cover property (irq);
  cover property (activeMode == `SCG_MODE_DEEP);
endmodule

/* File: dv/tb_sleep_mode_clock_gate_enables.sv */
// Purpose: Self-checking bench for the sleep clock gate block
// Assumes: Classic single Wishbone cycles, 100 MHz clock
// Notes: Read data and fault units checked from queues by a monitor
`timescale 1ns/1ns
`include "scgate_map.vh"
module tb_sleep_mode_clock_gate_enables;
  logic sys_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [11:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic wb_ack_o, busFault, irq, sleepMode = 0, deepSleepMode = 0;
  logic [9:0] periphAccess = 0, unitClkEn, faultUnit;
  logic [1:0] activeMode;
  logic [31:0] qRd[$];
  logic [9:0] qFlt[$];
  logic [15:0] rnd = 16'h593a;
  int nFail = 0, numChecks = 0;
  int pos[10] = '{0, 1, 4, 12, 16, 17, 18, 24, 25, 26};
  logic [11:0] offs[7] = '{12'h104, 12'h114, 12'h124, 12'h130, 12'h140, 12'h144, 12'h200};
  scg_sleep_gate scg_sleep_gate_inst (.*);
  initial forever #5 sys_clk = ~sys_clk;
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task endSim;
    $display("checks %0d fails %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e) begin
      nFail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    qRd.push_back(e);
    bus(a, 0, 0);
  endtask
  task gap(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && !wb_we_i) chk(wb_dat_o, qRd.pop_front());
    if (busFault === 1'b1) chk(32'(faultUnit), 32'(qFlt.pop_front()));
  end
  initial begin
    #100000;
    nFail++;
    endSim;
  end
  initial begin
    gap(4);
    rst_n <= 1;
    foreach (offs[i]) rd(offs[i], 32'h0);
    repeat (4) begin
      rnd = lfsr(rnd);
      bus(12'h114, 1, {rnd, ~rnd});
      rd(12'h114, {rnd, ~rnd} & `SCG_IMPL_MASK);
    end
    bus(12'h114, 1, 32'hffffffff);
    wb_sel_i <= 4'h1;
    bus(12'h114, 1, 32'h0);
    wb_sel_i <= 4'hf;
    rd(12'h114, 32'h0707_1000);
    bus(12'h114, 1, 32'h0707_1000 | 32'h1);
    rd(12'h114, 32'h0707_1001);
    bus(12'h200, 1, 32'hffffffff);
    rd(12'h200, 32'h0);
    bus(12'h130, 1, 32'h1);
    sleepMode <= 1;
    for (int i = 0; i < 10; i++) begin
      bus(12'h114, 1, 32'h1 << pos[i]);
      gap(2);
      chk(32'(unitClkEn), 32'h1 << i);
      qFlt.push_back(~(10'h1 << i));
      periphAccess <= 10'h3ff;
      gap(1);
      periphAccess <= 0;
    end
    gap(2);
    chk(32'(irq), 32'h0);
    rd(12'h140, `SCG_IMPL_MASK);
    bus(12'h144, 1, 32'hffffffff);
    gap(2);
    chk(32'(irq), 32'h1);
    bus(12'h140, 1, 32'hffffffff);
    gap(2);
    chk(32'(irq), 32'h0);
    bus(12'h114, 1, 32'hffffffff);
    bus(12'h104, 1, 32'h10);
    gap(2);
    chk(32'(unitClkEn), 32'h3ff);
    chk(32'(activeMode), 32'h1);
    deepSleepMode <= 1;
    gap(3);
    chk(32'(unitClkEn), 32'h0);
    chk(32'(activeMode), 32'h2);
    bus(12'h130, 1, 32'h0);
    gap(2);
    chk(32'(unitClkEn), 32'h4);
    chk(32'(qFlt.size()), 32'h0);
    endSim;
  end
endmodule
bind scg_sleep_gate scg_sleep_gate_checker scg_sleep_gate_checker_inst (.*);
